// [verilog/pat_defines.vh]
// pat_defines.vh: register map, field positions and reset values of the
// protection alarm/trip aggregator; included by pat_aggregator.v
`ifndef PAT_DEFINES_VH
`define PAT_DEFINES_VH

// register byte offsets (low address byte)
`define PAT_OFF_CTRL      8'h00
`define PAT_OFF_ACTIVE    8'h04
`define PAT_OFF_SUPV      8'h08
`define PAT_OFF_PHCAP     8'h0C
`define PAT_OFF_TBLK      8'h10
`define PAT_OFF_STATUS    8'h14
`define PAT_OFF_EALARM    8'h18
`define PAT_OFF_ETRIP     8'h1C
`define PAT_OFF_IRQ_STAT  8'h20
`define PAT_OFF_IRQ_CLR   8'h24
`define PAT_OFF_IRQ_EN    8'h28
`define PAT_OFF_TCMD      8'h2C
`define PAT_OFF_DLY_BASE  8'h40

// control register fields
`define PAT_CTRL_FN        0
`define PAT_CTRL_EXT_BLK   1
`define PAT_CTRL_PERM_TBLK 2
`define PAT_CTRL_EXT_TBLK  3
`define PAT_CTRL_W         4
`define PAT_CTRL_RST       4'h0

// status register fields
`define PAT_ST_GALARM   0
`define PAT_ST_GTRIP    1
`define PAT_ST_ALARM_A  2
`define PAT_ST_ALARM_B  3
`define PAT_ST_ALARM_C  4
`define PAT_ST_TRIP_A   5
`define PAT_ST_TRIP_B   6
`define PAT_ST_TRIP_C   7
`define PAT_ST_PBLK     8
`define PAT_ST_TBLK     9

// interrupt event fields
`define PAT_IRQ_GALARM  0
`define PAT_IRQ_GTRIP   1
`define PAT_IRQ_TCMD    2
`define PAT_IRQ_PBLK    3
`define PAT_IRQ_W       4
`define PAT_IRQ_RST     4'h0

`endif

// [verilog/pat_aggregator.v]
// pat_aggregator.v: master protection frame; per-element alarm/trip with
// delay timers, collective alarm/trip, blocking and trip commands.
// assumes synchronous element inputs and a single AHB-Lite master.
//
// Contract
// - element alarm rises as soon as its fault criterion is present.
// - element trip only if fault persists after its own delay expires.
// - general alarm is OR of contributing element alarms.
// - general trip is OR of contributing element trips.
// - supervision-only elements keep local states but never feed collectives.
// - supervision-only elements have no trip command nor its blocking.
// - unblocked non-supervision element commands trip on general trip.
// - master function off or frame blocked kills alarms, trips, commands.
// - external block enabled blocks protection while either block input true.
// - permanent command block suppresses commands; alarms, trips continue.
// - external trip-block enable suppresses commands while input true.
// - single-phase capable non-supervision elements feed phase collectives.
// - phase collective alarm is OR of element alarms concerning that phase.
// - phase collective trip is OR of element trips concerning that phase.
`timescale 1ns/1ps
`include "pat_defines.vh"

module pat_aggregator #(
   parameter N_ELEM = 8,
   parameter DLY_W  = 16
) (
   // clock and reset
   input  wire              hclk,
   input  wire              hresetn,
   // ahb-lite slave
   input  wire              hsel,
   input  wire [31:0]       haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hready,
   output reg  [31:0]       hrdata,
   output reg               hreadyout,
   output reg               hresp,
   // protection elements
   input  wire [N_ELEM-1:0] fault_in,
   input  wire [N_ELEM-1:0] fault_ph_a,
   input  wire [N_ELEM-1:0] fault_ph_b,
   input  wire [N_ELEM-1:0] fault_ph_c,
   // external blocking inputs
   input  wire              ext_block_in_a,
   input  wire              ext_block_in_b,
   input  wire              ext_trip_block_in,
   // element-local states
   output reg  [N_ELEM-1:0] elem_alarm,
   output reg  [N_ELEM-1:0] elem_trip,
   // collective signals
   output reg               gen_alarm,
   output reg               gen_trip,
   output reg               collective_alarm_phase_a,
   output reg               collective_alarm_phase_b,
   output reg               collective_alarm_phase_c,
   output reg               collective_trip_phase_a,
   output reg               collective_trip_phase_b,
   output reg               collective_trip_phase_c,
   output reg               prot_blocked,
   // breaker trip manager
   output reg  [N_ELEM-1:0] trip_command,
   // interrupt
   output reg               irq
);

   // software state
   reg [`PAT_CTRL_W-1:0] ctrl_r;
   reg [N_ELEM-1:0]      act_r;
   reg [N_ELEM-1:0]      supv_r;
   reg [N_ELEM-1:0]      phcap_r;
   reg [N_ELEM-1:0]      tblk_r;
   reg [DLY_W-1:0]       dly_r [0:N_ELEM-1];
   reg [DLY_W-1:0]       cnt_r [0:N_ELEM-1];
   reg [`PAT_IRQ_W-1:0]  irq_stat_r;
   reg [`PAT_IRQ_W-1:0]  irq_en_r;

   // bus data-phase capture
   reg                   wr_pend_r;
   reg [7:0]             wr_addr_r;

   // combinational terms
   reg                   prot_blk;
   reg                   tcmd_blk;
   reg [N_ELEM-1:0]      eff_on;
   reg [N_ELEM-1:0]      alarm_nxt;
   reg [N_ELEM-1:0]      trip_nxt;
   reg [N_ELEM-1:0]      held;
   reg [N_ELEM-1:0]      contrib;
   reg [N_ELEM-1:0]      tcmd_nxt;
   reg                   galarm_nxt;
   reg                   gtrip_nxt;
   reg [2:0]             ph_alarm_nxt;
   reg [2:0]             ph_trip_nxt;
   reg [`PAT_IRQ_W-1:0]  irq_evt;
   reg [`PAT_IRQ_W-1:0]  irq_stat_nxt;
   reg [31:0]            rd_word;
   reg [9:0]             status_w;

   wire addr_ph = hsel & htrans[1] & hready;
   // one loop index per process keeps every variable single-driven
   integer i;
   integer ti;
   integer wi;

   // delay slot decode: index of a delay register, or N_ELEM if none
   function integer dly_slot;
      input [7:0] a;
      integer k;
      begin
         dly_slot = N_ELEM;
         for (k = 0; k < N_ELEM; k = k + 1) begin
            if (a == `PAT_OFF_DLY_BASE + (k * 4))
               dly_slot = k;
         end
      end
   endfunction

   always @* begin
      prot_blk = ctrl_r[`PAT_CTRL_EXT_BLK] &
                 (ext_block_in_a | ext_block_in_b);
      tcmd_blk = ctrl_r[`PAT_CTRL_PERM_TBLK] |
                 (ctrl_r[`PAT_CTRL_EXT_TBLK] & ext_trip_block_in);
      contrib = ~supv_r;
      for (i = 0; i < N_ELEM; i = i + 1) begin
         eff_on[i] = ctrl_r[`PAT_CTRL_FN] & ~prot_blk & act_r[i];
         alarm_nxt[i] = eff_on[i] & fault_in[i];
         // trip after delay with fault held
         held[i] = (cnt_r[i] >= dly_r[i]);
         trip_nxt[i] = alarm_nxt[i] & held[i];
      end
      galarm_nxt = |(alarm_nxt & contrib);
      gtrip_nxt = |(trip_nxt & contrib);
      // phase outputs also need the element's phase-capable bit
      // phase collective alarms and trips
      ph_alarm_nxt[0] = |(alarm_nxt & contrib & phcap_r & fault_ph_a);
      ph_alarm_nxt[1] = |(alarm_nxt & contrib & phcap_r & fault_ph_b);
      ph_alarm_nxt[2] = |(alarm_nxt & contrib & phcap_r & fault_ph_c);
      ph_trip_nxt[0] = |(trip_nxt & contrib & phcap_r & fault_ph_a);
      ph_trip_nxt[1] = |(trip_nxt & contrib & phcap_r & fault_ph_b);
      ph_trip_nxt[2] = |(trip_nxt & contrib & phcap_r & fault_ph_c);
      // blocked commands still leave the general trip visible
      // trip command per contributing element
      tcmd_nxt = {N_ELEM{gtrip_nxt & ~tcmd_blk}} & contrib & eff_on &
                 ~tblk_r;
      // rising-edge events
      irq_evt = {prot_blk & ~prot_blocked,
                 (|tcmd_nxt) & ~(|trip_command),
                 gtrip_nxt & ~gen_trip,
                 galarm_nxt & ~gen_alarm};
      // set wins over software clear
      irq_stat_nxt = irq_stat_r;
      if (wr_pend_r && wr_addr_r == `PAT_OFF_IRQ_CLR)
         irq_stat_nxt = irq_stat_nxt & ~hwdata[`PAT_IRQ_W-1:0];
      irq_stat_nxt = irq_stat_nxt | irq_evt;
   end

   // element delay timers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (ti = 0; ti < N_ELEM; ti = ti + 1)
            cnt_r[ti] <= {DLY_W{1'b0}};
      end else begin
         for (ti = 0; ti < N_ELEM; ti = ti + 1) begin
            if (!alarm_nxt[ti])
               cnt_r[ti] <= {DLY_W{1'b0}};
            // counter stops at the delay so a long fault cannot wrap it
            else if (!held[ti])
               cnt_r[ti] <= cnt_r[ti] + {{(DLY_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         elem_alarm               <= {N_ELEM{1'b0}};
         elem_trip                <= {N_ELEM{1'b0}};
         gen_alarm                <= 1'b0;
         gen_trip                 <= 1'b0;
         collective_alarm_phase_a <= 1'b0;
         collective_alarm_phase_b <= 1'b0;
         collective_alarm_phase_c <= 1'b0;
         collective_trip_phase_a  <= 1'b0;
         collective_trip_phase_b  <= 1'b0;
         collective_trip_phase_c  <= 1'b0;
         prot_blocked             <= 1'b0;
         trip_command             <= {N_ELEM{1'b0}};
         irq_stat_r               <= `PAT_IRQ_RST;
         irq                      <= 1'b0;
      end else begin
         elem_alarm               <= alarm_nxt;
         elem_trip                <= trip_nxt;
         gen_alarm                <= galarm_nxt;
         gen_trip                 <= gtrip_nxt;
         collective_alarm_phase_a <= ph_alarm_nxt[0];
         collective_alarm_phase_b <= ph_alarm_nxt[1];
         collective_alarm_phase_c <= ph_alarm_nxt[2];
         collective_trip_phase_a  <= ph_trip_nxt[0];
         collective_trip_phase_b  <= ph_trip_nxt[1];
         collective_trip_phase_c  <= ph_trip_nxt[2];
         prot_blocked             <= prot_blk;
         trip_command             <= tcmd_nxt;
         irq_stat_r               <= irq_stat_nxt;
         // irq follows the next status so it rises with its event
         irq                      <= |(irq_stat_nxt & irq_en_r);
      end
   end

   // read mux, evaluated in the address phase
   always @* begin
      // bit 9 shows the live command block, not a registered copy
      status_w = {tcmd_blk, prot_blocked,
                  collective_trip_phase_c, collective_trip_phase_b,
                  collective_trip_phase_a, collective_alarm_phase_c,
                  collective_alarm_phase_b, collective_alarm_phase_a,
                  gen_trip, gen_alarm};
      rd_word = 32'h0000_0000;
      case ({haddr[7:2], 2'b00})
         `PAT_OFF_CTRL:     rd_word[`PAT_CTRL_W-1:0] = ctrl_r;
         `PAT_OFF_ACTIVE:   rd_word[N_ELEM-1:0] = act_r;
         `PAT_OFF_SUPV:     rd_word[N_ELEM-1:0] = supv_r;
         `PAT_OFF_PHCAP:    rd_word[N_ELEM-1:0] = phcap_r;
         `PAT_OFF_TBLK:     rd_word[N_ELEM-1:0] = tblk_r;
         `PAT_OFF_STATUS:   rd_word[9:0] = status_w;
         `PAT_OFF_EALARM:   rd_word[N_ELEM-1:0] = elem_alarm;
         `PAT_OFF_ETRIP:    rd_word[N_ELEM-1:0] = elem_trip;
         `PAT_OFF_IRQ_STAT: rd_word[`PAT_IRQ_W-1:0] = irq_stat_r;
         `PAT_OFF_IRQ_EN:   rd_word[`PAT_IRQ_W-1:0] = irq_en_r;
         `PAT_OFF_TCMD:     rd_word[N_ELEM-1:0] = trip_command;
         // the clear register is write-only and reads 0 here
         default: begin
            if (dly_slot({haddr[7:2], 2'b00}) < N_ELEM)
               rd_word[DLY_W-1:0] = dly_r[dly_slot({haddr[7:2], 2'b00})];
         end
      endcase
   end

   // ahb-lite slave: zero wait states, always okay
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         // every transfer completes okay with no wait state
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= addr_ph & hwrite;
         if (addr_ph)
            wr_addr_r <= {haddr[7:2], 2'b00};
         if (addr_ph && !hwrite)
            hrdata <= rd_word;
      end
   end

   // register writes in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r   <= `PAT_CTRL_RST;
         act_r    <= {N_ELEM{1'b0}};
         supv_r   <= {N_ELEM{1'b0}};
         phcap_r  <= {N_ELEM{1'b0}};
         tblk_r   <= {N_ELEM{1'b0}};
         irq_en_r <= `PAT_IRQ_RST;
         for (wi = 0; wi < N_ELEM; wi = wi + 1)
            dly_r[wi] <= {DLY_W{1'b0}};
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `PAT_OFF_CTRL:   ctrl_r   <= hwdata[`PAT_CTRL_W-1:0];
            `PAT_OFF_ACTIVE: act_r    <= hwdata[N_ELEM-1:0];
            `PAT_OFF_SUPV:   supv_r   <= hwdata[N_ELEM-1:0];
            `PAT_OFF_PHCAP:  phcap_r  <= hwdata[N_ELEM-1:0];
            `PAT_OFF_TBLK:   tblk_r   <= hwdata[N_ELEM-1:0];
            `PAT_OFF_IRQ_EN: irq_en_r <= hwdata[`PAT_IRQ_W-1:0];
            // unmapped offsets match no slot and are dropped
            default: begin
               for (wi = 0; wi < N_ELEM; wi = wi + 1) begin
                  if (dly_slot(wr_addr_r) == wi)
                     dly_r[wi] <= hwdata[DLY_W-1:0];
               end
            end
         endcase
      end
   end

endmodule // pat_aggregator

// [verification/pat_checker.sv]
// pat_checker.sv: port-level checks of the alarm/trip aggregator
// assumes one hclk domain and asynchronous active-low hresetn
`timescale 1ns/1ps
module pat_checker #(
   parameter N_ELEM = 8
) (
   // clock and reset
   input wire              hclk,
   input wire              hresetn,
   // element side
   input wire [N_ELEM-1:0] fault_in,
   input wire [N_ELEM-1:0] elem_alarm,
   input wire [N_ELEM-1:0] elem_trip,
   // collectives
   input wire              gen_alarm,
   input wire              gen_trip,
   input wire              collective_alarm_phase_a,
   input wire              collective_trip_phase_a,
   input wire              prot_blocked,
   input wire [N_ELEM-1:0] trip_command
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_alarm_cause: assert property (
      (elem_alarm & ~$past(fault_in)) == 0) else $error("alarm, no fault");
   a_trip_cause: assert property (
      ((elem_trip & ~elem_alarm) | (elem_trip & ~$past(fault_in))) == 0)
      else $error("trip without alarm or fault");
   a_gen_alarm: assert property (gen_alarm |-> |elem_alarm)
      else $error("general alarm without element alarm");
   a_gen_trip: assert property (gen_trip |-> |elem_trip)
      else $error("general trip without element trip");
   a_cmd_trip: assert property (|trip_command |-> gen_trip)
      else $error("trip command without general trip");
   a_block_quiet: assert property (
      prot_blocked |-> !gen_alarm && !gen_trip && trip_command == 0)
      else $error("output while protection blocked");
   a_phase_alarm: assert property (
      collective_alarm_phase_a |-> gen_alarm) else $error("phase alarm");
   a_phase_trip: assert property (
      collective_trip_phase_a |-> gen_trip && collective_alarm_phase_a)
      else $error("phase trip without trip or phase alarm");
   a_drop_clear: assert property (
      $past(fault_in) == 0 |-> !gen_alarm && trip_command == 0)
      else $error("collective held after fault drop");
endmodule // pat_checker

// [verification/pat_elem_model.sv]
// pat_elem_model.sv: protection elements and block contacts
// assumes the bench calls drive() from one process at a time
`timescale 1ns/1ps
module pat_elem_model #(
   parameter N = 8
) (
   // clock
   input  wire          hclk,
   // element levels
   output logic [N-1:0] fault_in,
   output logic [N-1:0] fault_ph_a,
   output logic [N-1:0] fault_ph_b,
   output logic [N-1:0] fault_ph_c,
   // block contacts
   output logic         ext_block_in_a,
   output logic         ext_block_in_b,
   output logic         ext_trip_block_in
);
   initial begin
      {fault_in, fault_ph_a, fault_ph_b, fault_ph_c} = '0;
      {ext_trip_block_in, ext_block_in_b, ext_block_in_a} = 3'h0;
   end

   // phases of idle elements are random: they must not matter
   // p: phases a, b, c that the faulted element concerns
   task automatic drive(input int e, input logic on, input logic [2:0] b,
                        input logic [2:0] p);
      logic [N-1:0] s;
      s = N'(on) << e;
      @(posedge hclk);
      fault_in <= s;
      fault_ph_a <= (N'($urandom) & ~s) | (p[0] ? s : N'(0));
      fault_ph_b <= (N'($urandom) & ~s) | (p[1] ? s : N'(0));
      fault_ph_c <= (N'($urandom) & ~s) | (p[2] ? s : N'(0));
      {ext_trip_block_in, ext_block_in_b, ext_block_in_a} <= b;
   endtask
endmodule // pat_elem_model

// [verification/protection_alarm_trip_aggregator_tb.sv]
// protection_alarm_trip_aggregator_tb.sv: self-checking bench
// assumes zero-wait ahb-lite slave and the element model as stimulus
`timescale 1ns/1ps
`include "pat_defines.vh"
module protection_alarm_trip_aggregator_tb;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
   logic        hwrite = 1'b0, rd_ph = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   wire  [31:0] hrdata;
   wire  [7:0]  fi, pa, pb, pc, ea, et, tc;
   wire         hro, hresp, ba, bb, bt, ga, gt, pbk, irq;
   wire  [2:0]  cal, ctr;
   wire  [9:0]  lvl = {irq, pbk, ctr, cal, gt, ga};
   int          mismatches = 0, total_checks = 0;
   int          dly [8];
   logic [7:0]  tblk_m = 8'h0;
   logic [31:0] exp_q [$];
   logic [3:0]  ctl_t [6] = '{4'h3, 4'h3, 4'h5, 4'h9, 4'h0, 4'h1};
   logic [2:0]  blk_t [6] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h0, 3'h7};
   logic [3:0]  f_t [6] = '{4'h1, 4'h1, 4'hC, 4'hC, 4'h0, 4'hE};

   pat_aggregator #(.N_ELEM(8), .DLY_W(16)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hro), .hrdata(hrdata), .hreadyout(hro), .hresp(hresp),
      .fault_in(fi), .fault_ph_a(pa), .fault_ph_b(pb), .fault_ph_c(pc),
      .ext_block_in_a(ba), .ext_block_in_b(bb), .ext_trip_block_in(bt),
      .elem_alarm(ea), .elem_trip(et), .gen_alarm(ga), .gen_trip(gt),
      .collective_alarm_phase_a(cal[0]), .collective_alarm_phase_b(cal[1]),
      .collective_alarm_phase_c(cal[2]), .collective_trip_phase_a(ctr[0]),
      .collective_trip_phase_b(ctr[1]), .collective_trip_phase_c(ctr[2]),
      .prot_blocked(pbk), .trip_command(tc), .irq(irq));
   pat_elem_model #(.N(8)) elm (.hclk(hclk), .fault_in(fi),
      .fault_ph_a(pa), .fault_ph_b(pb), .fault_ph_c(pc),
      .ext_block_in_a(ba), .ext_block_in_b(bb), .ext_trip_block_in(bt));

   always #5 hclk = ~hclk;

   task automatic chk(input string nm, input logic [31:0] ex, got);
      total_checks++;
      if (got !== ex) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // one single transfer; for a read, d is the expected data
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hro !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= w ? d : 32'h0;
      rd_ph <= !w;
      if (!w) exp_q.push_back(d);
      do @(posedge hclk); while (hro !== 1'b1);
      rd_ph <= 1'b0;
   endtask

   always @(posedge hclk)
      if (rd_ph && hro === 1'b1 && exp_q.size() > 0) begin
         chk("hrdata", exp_q.pop_front(), hrdata);
         chk("hresp", 32'h0, 32'(hresp));
      end

   // f: alarm, trip, command, blocked expected for a fault on element e
   task automatic run(input int e, input logic [2:0] b, input logic [3:0] f);
      logic tr, c, ph;
      logic [2:0] p;
      logic [7:0] cm;
      logic [9:0] lv;
      c = (e != 7);
      ph = c && e < 4;
      p = 3'($urandom_range(7, 1));
      elm.drive(e, 1'b1, b, p);
      for (int k = 1; k <= dly[e] + 2; k++) begin
         @(posedge hclk);
         #1;
         tr = f[2] && k > dly[e];
         cm = (tr && f[1] && c) ? (8'h7F & ~tblk_m) : 8'h0;
         lv = {1'b0, f[0], {3{tr && ph}} & p, {3{f[3] && ph}} & p,
               tr && c, f[3] && c};
         chk("elem_alarm", 32'(f[3]) << e, 32'(ea));
         chk("elem_trip", 32'(tr) << e, 32'(et));
         chk("trip_command", 32'(cm), 32'(tc));
         chk("levels", 32'(lv), 32'(lvl));
      end
      elm.drive(e, 1'b0, 3'h0, 3'h0);
      repeat (2) @(posedge hclk);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h1999));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(`PAT_OFF_CTRL, 1'b0, 32'h0);
      xfer(`PAT_OFF_STATUS, 1'b0, 32'h0);
      xfer(8'h3C, 1'b0, 32'h0);
      $display("reset test done");
      xfer(`PAT_OFF_CTRL, 1'b1, 32'h1);
      xfer(`PAT_OFF_ACTIVE, 1'b1, 32'hFF);
      xfer(`PAT_OFF_SUPV, 1'b1, 32'h80);
      xfer(`PAT_OFF_PHCAP, 1'b1, 32'h0F);
      for (int i = 0; i < 8; i++) begin
         dly[i] = $urandom_range(3);
         xfer(`PAT_OFF_DLY_BASE + 8'(4 * i), 1'b1, 32'(dly[i]));
      end
      xfer(`PAT_OFF_SUPV, 1'b0, 32'h80);
      xfer(`PAT_OFF_DLY_BASE + 8'h4, 1'b0, 32'(dly[1]));
      $display("config test done");
      run($urandom_range(3), 3'h0, 4'hE);
      run(4 + $urandom_range(2), 3'h0, 4'hE);
      run(7, 3'h0, 4'hC);
      $display("element test done");
      for (int m = 0; m < 6; m++) begin
         xfer(`PAT_OFF_CTRL, 1'b1, 32'(ctl_t[m]));
         run($urandom_range(6), blk_t[m], f_t[m]);
      end
      xfer(`PAT_OFF_CTRL, 1'b1, 32'h1);
      tblk_m = 8'($urandom);
      xfer(`PAT_OFF_TBLK, 1'b1, 32'(tblk_m));
      run($urandom_range(6), 3'h0, 4'hE);
      tblk_m = 8'h0;
      xfer(`PAT_OFF_TBLK, 1'b1, 32'h0);
      xfer(`PAT_OFF_ACTIVE, 1'b1, 32'hFE);
      run(0, 3'h0, 4'h0);
      xfer(`PAT_OFF_ACTIVE, 1'b1, 32'hFF);
      $display("blocking test done");
      xfer(`PAT_OFF_IRQ_CLR, 1'b1, 32'hF);
      xfer(`PAT_OFF_IRQ_EN, 1'b1, 32'h2);
      elm.drive(1, 1'b1, 3'h0, 3'h1);
      repeat (dly[1] + 2) @(posedge hclk);
      #1;
      chk("irq", 32'h1, 32'(irq));
      xfer(`PAT_OFF_IRQ_STAT, 1'b0, 32'h7);
      xfer(`PAT_OFF_IRQ_EN, 1'b1, 32'h0);
      elm.drive(1, 1'b0, 3'h0, 3'h0);
      #1;
      chk("irq", 32'h0, 32'(irq));
      xfer(`PAT_OFF_IRQ_CLR, 1'b1, 32'h2);
      xfer(`PAT_OFF_IRQ_STAT, 1'b0, 32'h5);
      xfer(`PAT_OFF_IRQ_CLR, 1'b0, 32'h0);
      $display("interrupt test done");
      finish_test();
   end
endmodule // protection_alarm_trip_aggregator_tb

bind pat_aggregator pat_checker #(.N_ELEM(N_ELEM)) u_chk (.hclk(hclk),
   .hresetn(hresetn), .fault_in(fault_in), .elem_alarm(elem_alarm),
   .elem_trip(elem_trip), .gen_alarm(gen_alarm), .gen_trip(gen_trip),
   .collective_alarm_phase_a(collective_alarm_phase_a),
   .collective_trip_phase_a(collective_trip_phase_a),
   .prot_blocked(prot_blocked), .trip_command(trip_command));
